// [design/smc_pkg.sv]
// shared constants and types for the switching-mode control register bank
package smc_pkg;

    // ************************************************************
    // register map, bank-independent and bank 0/1 offsets
    // ************************************************************
    localparam int          ADDR_W            = 4;
    localparam logic [3:0]  REG_MEM_DATA      = 4'h0;
    localparam logic [3:0]  REG_MEM_CMD       = 4'h1;
    localparam logic [3:0]  REG_MEM_ADDR      = 4'h2;
    localparam logic [3:0]  REG_ACCESS_STATUS = 4'h3;
    localparam logic [3:0]  REG_PCM_RX        = 4'h4;
    localparam logic [3:0]  REG_VERSION       = 4'hD;
    localparam logic [3:0]  REG_MODE          = 4'hF;

    // ************************************************************
    // operating mode register fields and reset value
    // ************************************************************
    localparam int          MODE_SEL_LSB      = 6;
    localparam int          PCM_OE_BIT        = 5;
    localparam int          PCM_LOOP_BIT      = 4;
    localparam int          DRV_TYPE_BIT      = 3;
    localparam int          MON_HS_BIT        = 2;
    localparam int          SUB_OE_BIT        = 1;
    localparam int          BANK_BIT          = 0;
    localparam logic [7:0]  MODE_RESET_VAL    = 8'h00;

    // ************************************************************
    // memory access command and status fields
    // ************************************************************
    localparam logic [3:0]  CMD_RESET_NIB     = 4'h7;
    localparam int          CMD_READ_BIT      = 0;
    localparam int          CMD_TRI_BIT       = 1;
    localparam int          STAT_BUSY_BIT     = 0;
    localparam int          STAT_INIT_REQ_BIT = 1;
    localparam int          STAT_SEARCH_BIT   = 2;
    localparam int          SEARCH_START_BIT  = 0;
    localparam int          VER_INIT_REQ_BIT  = 7;
    localparam logic [3:0]  CODE_UNASSIGNED   = 4'h0;
    localparam logic [7:0]  BOOT_RESET_CMD    = 8'h70;
    localparam logic [7:0]  BOOT_RESET_DATA   = 8'h00;

    // ************************************************************
    // access durations in reference clock cycles
    // ************************************************************
    localparam int          CNT_W             = 12;
    localparam int          INIT_ACCESS_X10   = 25;
    localparam int          NORMAL_ACCESS_X10 = 95;
    localparam logic [11:0] CM_RESET_CYCLES   = 12'd256;
    localparam logic [11:0] TEST_CYCLES       = 12'd2057;
    localparam logic [11:0] TRI_INIT_CYCLES   = 12'd1035;
    // longest time rounds down, least time rounds up
    localparam logic [11:0] INIT_ACCESS_CYCLES =
        12'((INIT_ACCESS_X10 / 10 < 1) ? 1 : INIT_ACCESS_X10 / 10);
    localparam logic [11:0] NORMAL_ACCESS_CYCLES = 12'((NORMAL_ACCESS_X10 + 9) / 10);

    typedef enum logic [1:0] {
        MODE_CM_RESET = 2'b00,
        MODE_TEST     = 2'b01,
        MODE_INIT     = 2'b10,
        MODE_NORMAL   = 2'b11
    } op_mode_t;

endpackage

// [design/smc_bus_if.sv]
// parallel register bus between host controller and switching device
`timescale 1ns/1ns
interface smc_bus_if;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;

    modport device (input addr, input wdata, input wr, input rd, output rdata);
    modport host   (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// [design/switch_mode_control_dev.sv]
// switching device end: mode and version registers, control memory, interface gating
// Contract
// - mode 00 clears whole memory within 256 cycles; tristate bits keep their values
// - reset mode keeps both interfaces idle
// - command 70 writes data, code 0000 everywhere
// - mode 10 single access, at most 2.5 cycles
// - mode 11 runs interfaces, 9.5 / 1035 cycles
// - mode 01 hits all locations, 2057 cycles
// - pcm standby 0 floats tx, tristate pin high
// - pcm standby 1 sends memory, per-slot tristate
// - loop bit routes tx to receive path
// - driver type 0 tristate, 1 open drain
// - monitor bit enables channel handshake
// - subscriber standby 0 floats its four outputs
// - bank bit selects register bank; mode always
// - init flag set on fault, cleared by reset command
// - read-only four-bit version in low bits
// - software writes alternate input fields as 00
// - software writes port select fields as 00
// - software writes subchannel port fields as 00
// - software keeps mismatch interrupt masked
// - software resets control memory after hardware reset
// - search stops on found channel or bit6 clear
`timescale 1ns/1ns
module switch_mode_control_dev
    import smc_pkg::*;
#(
    parameter int         DEPTH        = 32,
    parameter logic [3:0] VERSION_CODE = 4'hA,  // arbitrary value
    parameter int         BIT_DIV      = 4
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic resetn,
    // register bus
    smc_bus_if.device bus,
    // pcm interface
    output logic      pcmTxOut,
    output logic      pcmTxOe,
    output logic      tristateControlPin,
    input  wire logic pcmRxPin,
    // subscriber interface
    output logic      subDownstreamData,
    output logic      subDownstreamOe,
    output logic      subUpstreamData,
    output logic      subUpstreamOe,
    output logic      subDataClock,
    output logic      subDataClockOe,
    output logic      subFrameSync,
    output logic      subFrameSyncOe,
    // monitor channel and supervision
    output logic      monitorHandshakeEnable,
    input  wire logic monitorActivePin,
    input  wire logic powerFailPin
);
    localparam int AW = $clog2(DEPTH);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } access_state_t;

    // ************************************************************
    // registers and storage
    // ************************************************************
    logic [7:0]       modeReg;
    logic [7:0]       memData;
    logic [7:0]       memCmd;
    logic [7:0]       memAddr;
    logic [7:0]       readBack;
    logic [7:0]       pcmRxByte;
    logic [7:0]       rxShift;
    logic [CNT_W-1:0] remain;
    op_mode_t         accMode;
    access_state_t    state;
    logic             initReq;
    logic             searchActive;
    logic [3:0]       codeMem [DEPTH];
    logic [7:0]       dataMem [DEPTH];
    logic             triMem  [DEPTH];
    logic [1:0]       rxSync;
    logic [1:0]       monSync;
    logic [1:0]       failSync;
    logic [$clog2(BIT_DIV)-1:0] divCnt;
    logic             bitTick;
    logic [2:0]       bitCnt;
    logic [AW-1:0]    slot;

    wire logic        bank    = modeReg[BANK_BIT];
    op_mode_t         liveMode;
    assign liveMode = op_mode_t'(modeReg[7:MODE_SEL_LSB]);
    wire logic        cmdWrite = bus.wr && !bank && bus.addr == REG_MEM_CMD;
    wire logic        accDone  = state == ST_BUSY && remain == 12'h001;
    wire logic        isResetCmd = accMode == MODE_CM_RESET && memCmd[7:4] == CMD_RESET_NIB;
    wire logic [AW-1:0] accAddr = (accMode == MODE_TEST) ? '0 : memAddr[AW-1:0];

    function automatic logic [CNT_W-1:0] accessCycles(op_mode_t m, logic triSel);
        unique case (m)
            MODE_CM_RESET: accessCycles = CM_RESET_CYCLES;
            MODE_INIT:     accessCycles = INIT_ACCESS_CYCLES;
            MODE_NORMAL:   accessCycles = triSel ? TRI_INIT_CYCLES
                                              : NORMAL_ACCESS_CYCLES;
            MODE_TEST:     accessCycles = TEST_CYCLES;
        endcase
    endfunction

    // ************************************************************
    // input synchronisers
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rxSync   <= 2'h0;
            monSync  <= 2'h0;
            failSync <= 2'h0;
        end else begin
            rxSync   <= {rxSync[0], pcmRxPin};
            monSync  <= {monSync[0], monitorActivePin};
            failSync <= {failSync[0], powerFailPin};
        end
    end

    // ************************************************************
    // register writes
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            modeReg <= MODE_RESET_VAL;
            memData <= 8'h00;
            memAddr <= 8'h00;
        end else if (bus.wr) begin
            if (bus.addr == REG_MODE)
                modeReg <= bus.wdata;
            else if (!bank && bus.addr == REG_MEM_DATA)
                memData <= bus.wdata;
            else if (!bank && bus.addr == REG_MEM_ADDR)
                memAddr <= bus.wdata;
        end
    end

    // ************************************************************
    // memory access sequencer
    // ************************************************************
    // mode is sampled at command time so a later mode write only affects the next access
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state   <= ST_IDLE;
            remain  <= 12'h000;
            memCmd  <= 8'h00;
            accMode <= MODE_CM_RESET;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (cmdWrite) begin
                        memCmd  <= bus.wdata;
                        accMode <= liveMode;
                        remain  <= accessCycles(liveMode, bus.wdata[CMD_TRI_BIT]);
                        state   <= ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    remain <= remain - 12'h001;
                    if (accDone)
                        state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // storage has no reset: a control memory reset command is what clears it
    always_ff @(posedge ref_clk) begin
        if (accDone) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (isResetCmd) begin
                    dataMem[i] <= memData;
                    codeMem[i] <= CODE_UNASSIGNED;
                end else if (!memCmd[CMD_READ_BIT]) begin
                    if (accMode == MODE_TEST && memCmd[CMD_TRI_BIT])
                        triMem[i] <= memData[0];
                    else if (accMode == MODE_TEST)
                        dataMem[i] <= memData;
                    else if (accMode == MODE_NORMAL && memCmd[CMD_TRI_BIT])
                        triMem[i] <= memData[0];
                    else if (accMode != MODE_CM_RESET && i == int'(accAddr))
                        dataMem[i] <= memData;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn)
            readBack <= 8'h00;
        else if (accDone && memCmd[CMD_READ_BIT])
            readBack <= dataMem[accAddr];
    end

    // ************************************************************
    // init request flag and monitor search
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (!resetn)
            initReq <= 1'b1;
        else if (failSync[1])
            initReq <= 1'b1;
        else if (accDone && isResetCmd)
            initReq <= 1'b0;
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn)
            searchActive <= 1'b0;
        else if (monSync[1] || !modeReg[MODE_SEL_LSB])
            searchActive <= 1'b0;
        else if (bus.wr && !bank && bus.addr == REG_ACCESS_STATUS
                 && bus.wdata[SEARCH_START_BIT])
            searchActive <= 1'b1;
    end

    assign monitorHandshakeEnable = modeReg[MON_HS_BIT];

    // ************************************************************
    // read port
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            bus.rdata <= 8'h00;
        end else if (bus.rd) begin
            bus.rdata <= 8'h00;
            if (bus.addr == REG_MODE)
                bus.rdata <= modeReg;
            else if (bank && bus.addr == REG_VERSION)
                bus.rdata <= {initReq, 3'h0, VERSION_CODE};
            else if (!bank) begin
                unique case (bus.addr)
                    REG_MEM_DATA:      bus.rdata <= readBack;
                    REG_MEM_ADDR:      bus.rdata <= memAddr;
                    REG_ACCESS_STATUS: bus.rdata <= {5'h00, searchActive, initReq,
                                                     state == ST_BUSY};
                    REG_PCM_RX:        bus.rdata <= pcmRxByte;
                    default:           bus.rdata <= 8'h00;
                endcase
            end
        end
    end

    // ************************************************************
    // serial interfaces
    // ************************************************************
    wire logic ifActive = liveMode == MODE_NORMAL || liveMode == MODE_TEST;
    wire logic txBit    = dataMem[slot][3'd7 - bitCnt];
    wire logic txDrive  = ifActive && modeReg[PCM_OE_BIT] && !triMem[slot];
    wire logic rxBit    = modeReg[PCM_LOOP_BIT] ? txBit : rxSync[1];
    wire logic subEn    = ifActive && modeReg[SUB_OE_BIT];
    wire logic openDrain = modeReg[DRV_TYPE_BIT];

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            divCnt  <= '0;
            bitTick <= 1'b0;
        end else begin
            bitTick <= divCnt == '0;
            divCnt  <= (int'(divCnt) == BIT_DIV - 1) ? '0 : divCnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn || !ifActive) begin
            bitCnt    <= 3'h0;
            slot      <= '0;
            rxShift   <= 8'h00;
            pcmRxByte <= 8'h00;
        end else if (bitTick) begin
            bitCnt  <= bitCnt + 3'h1;
            rxShift <= {rxShift[6:0], rxBit};
            if (bitCnt == 3'h7) begin
                slot      <= slot + 1'b1;
                pcmRxByte <= {rxShift[6:0], rxBit};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            pcmTxOut           <= 1'b0;
            pcmTxOe            <= 1'b0;
            tristateControlPin <= 1'b1;
            subDownstreamData  <= 1'b1;
            subUpstreamData    <= 1'b1;
            subDataClock       <= 1'b1;
            subFrameSync       <= 1'b1;
        end else begin
            pcmTxOut           <= txBit;
            pcmTxOe            <= txDrive;
            tristateControlPin <= !txDrive;
            subDownstreamData  <= rxBit;
            subUpstreamData    <= txBit;
            subDataClock       <= divCnt < $clog2(BIT_DIV)'(BIT_DIV / 2);
            subFrameSync       <= !(slot == '0 && bitCnt == 3'h0);
        end
    end

    // open drain only pulls low; tristate drives both levels
    assign subDownstreamOe = subEn && (!openDrain || !subDownstreamData);
    assign subUpstreamOe   = subEn && (!openDrain || !subUpstreamData);
    assign subDataClockOe  = subEn && (!openDrain || !subDataClock);
    assign subFrameSyncOe  = subEn && (!openDrain || !subFrameSync);

endmodule // switch_mode_control_dev

// [design/switch_mode_control_host.sv]
// host end: boot sequence and user command port driving the register bus
`timescale 1ns/1ns
module switch_mode_control_host
    import smc_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    // register bus
    smc_bus_if.host         bus,
    // user command port
    input  wire logic       reqWr,
    input  wire logic       reqRd,
    input  wire logic [3:0] reqAddr,
    input  wire logic [7:0] reqData,
    output logic            reqReady,
    output logic            rspValid,
    output logic [7:0]      rspData
);
    typedef enum logic [3:0] {
        BOOT_DATA = 4'b0001,
        BOOT_CMD  = 4'b0010,
        BOOT_WAIT = 4'b0100,
        READY     = 4'b1000
    } host_state_t;

    host_state_t      state;
    logic [CNT_W-1:0] waitCnt;
    logic             rdPending;

    // ************************************************************
    // boot: control memory reset right after hardware reset
    // ************************************************************
    // mode is 00 out of reset, so only data and command need writing;
    // fields of registers outside this bank (alternate input, port select,
    // subchannel port, mismatch mask) are left to user writes of 00/1
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state   <= BOOT_DATA;
            waitCnt <= 12'h000;
            bus.wr    <= 1'b0;
            bus.rd    <= 1'b0;
            bus.addr  <= 4'h0;
            bus.wdata <= 8'h00;
        end else begin
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
            unique case (state)
                BOOT_DATA: begin
                    bus.wr    <= 1'b1;
                    bus.addr  <= REG_MEM_DATA;
                    bus.wdata <= BOOT_RESET_DATA;
                    state     <= BOOT_CMD;
                end
                BOOT_CMD: begin
                    bus.wr    <= 1'b1;
                    bus.addr  <= REG_MEM_CMD;
                    bus.wdata <= BOOT_RESET_CMD;
                    waitCnt   <= CM_RESET_CYCLES;
                    state     <= BOOT_WAIT;
                end
                BOOT_WAIT: begin
                    waitCnt <= waitCnt - 12'h001;
                    if (waitCnt == 12'h000)
                        state <= READY;
                end
                READY: begin
                    bus.wr    <= reqWr;
                    bus.rd    <= reqRd && !reqWr;
                    bus.addr  <= reqAddr;
                    bus.wdata <= reqData;
                end
                default: state <= BOOT_DATA;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn)
            rdPending <= 1'b0;
        else
            rdPending <= bus.rd;
    end

    assign reqReady = state == READY;
    assign rspValid = rdPending;
    assign rspData  = bus.rdata;

endmodule // switch_mode_control_host

// [tb/smc_bus_props.sv]
// bus-side property checker for the switching-mode control link
`timescale 1ns/1ns
module smc_bus_props
    import smc_pkg::*;
#(
    parameter logic [3:0] VERSION_CODE = 4'hA  // arbitrary value
) (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       resetn,
    // register bus
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata
);
    logic [7:0]  modeReg;
    logic [11:0] left;
    logic [11:0] dur;
    logic        bootSeen;
    logic        cmdWr;
    logic        stRd;
    assign cmdWr = wr && addr == REG_MEM_CMD && !modeReg[BANK_BIT];
    assign stRd  = rd && addr == REG_ACCESS_STATUS && !modeReg[BANK_BIT];
    assign dur   = (modeReg[7:6] == 2'b00) ? CM_RESET_CYCLES :
                   (modeReg[7:6] == 2'b10) ? INIT_ACCESS_CYCLES :
                   (modeReg[7:6] == 2'b01) ? TEST_CYCLES :
                   wdata[CMD_TRI_BIT] ? TRI_INIT_CYCLES : NORMAL_ACCESS_CYCLES;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    always_ff @(posedge ref_clk) begin
        if (!resetn) modeReg <= MODE_RESET_VAL;
        else if (wr && addr == REG_MODE) modeReg <= wdata;
    end
    always_ff @(posedge ref_clk) begin
        if (!resetn) bootSeen <= 1'b0;
        else if (wr) bootSeen <= 1'b1;
    end
    // two spare cycles before the end of busy, one after: busy edge alignment is the designer's choice
    always_ff @(posedge ref_clk) begin
        if (!resetn) left <= 12'h000;
        else if (cmdWr && left == 12'h000) left <= dur + 12'h001;
        else if (left != 12'h000) left <= left - 12'h001;
    end
    // ************************************************************
    // properties
    // ************************************************************
    a_no_dual_strobe:
        assert property (!(wr && rd)) else $error("both strobes high");
    a_mode_readback:
        assert property (rd && addr == REG_MODE |=> rdata == $past(modeReg))
        else $error("mode register read mismatch");
    a_version_fixed:
        assert property (rd && addr == REG_VERSION && modeReg[BANK_BIT]
            |=> rdata[6:0] == {3'b000, VERSION_CODE}) else $error("version field wrong");
    a_unmapped_zero:
        assert property (rd && (addr inside {[4'h5:4'hC], 4'hE}) |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_status_pad:
        assert property (stRd |=> rdata[7:3] == 5'h00) else $error("status pad bits set");
    a_busy_held:
        assert property (stRd && left > 12'h003 |=> rdata[STAT_BUSY_BIT])
        else $error("access ended early");
    a_busy_done:
        assert property (stRd && left == 12'h000 |=> !rdata[STAT_BUSY_BIT])
        else $error("access overran");
    a_boot_order:
        assert property (wr && !bootSeen |-> addr == REG_MEM_DATA
            && wdata == BOOT_RESET_DATA ##1 wr && addr == REG_MEM_CMD
            && wdata == BOOT_RESET_CMD) else $error("boot sequence wrong");
    c_cm_reset: cover property (cmdWr && modeReg[7:6] == 2'b00);
    c_version: cover property (rd && addr == REG_VERSION && modeReg[BANK_BIT]);
    c_busy_read: cover property (stRd && left > 12'h003);
endmodule // smc_bus_props

// [tb/tb.sv]
// self-checking bench: host and device ends joined over the register bus
`timescale 1ns/1ns
module tb;
    import smc_pkg::*;
    localparam logic [3:0] VER = 4'h5;  // arbitrary value
    localparam logic [7:0] MODES [4] = '{8'h80, 8'hC0, 8'hC0, 8'h40};
    localparam logic [7:0] CMDS [4]  = '{8'h00, 8'h00, 8'h02, 8'h00};
    localparam int         WAITS [4] = '{2, 10, 1035, 2057};
    logic       ref_clk, resetn, reqWr, reqRd, reqReady, rspValid;
    logic [3:0] reqAddr;
    logic [7:0] reqData, rspData;
    logic       pcmRxPin, monitorActivePin, powerFailPin, pcmTxOe, tristateControlPin;
    logic       subDataClock, subDataClockOe, subFrameSyncOe, monitorHandshakeEnable;
    logic [15:0] expQ [$];
    int         failures, cmp_count, cycles;
    smc_bus_if bus ();
    switch_mode_control_host i_switch_mode_control_host (.ref_clk(ref_clk), .resetn(resetn),
        .bus(bus), .reqWr(reqWr), .reqRd(reqRd), .reqAddr(reqAddr), .reqData(reqData),
        .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData));
    switch_mode_control_dev #(.DEPTH(32), .VERSION_CODE(VER), .BIT_DIV(2))
        i_switch_mode_control_dev (.ref_clk(ref_clk), .resetn(resetn), .bus(bus),
        .pcmTxOut(), .pcmTxOe(pcmTxOe), .tristateControlPin(tristateControlPin),
        .pcmRxPin(pcmRxPin), .subDownstreamData(), .subDownstreamOe(), .subUpstreamData(),
        .subUpstreamOe(), .subDataClock(subDataClock), .subDataClockOe(subDataClockOe),
        .subFrameSync(), .subFrameSyncOe(subFrameSyncOe),
        .monitorHandshakeEnable(monitorHandshakeEnable),
        .monitorActivePin(monitorActivePin), .powerFailPin(powerFailPin));
    smc_bus_props #(.VERSION_CODE(VER)) i_smc_bus_props (.ref_clk(ref_clk), .resetn(resetn),
        .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata));
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic req(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reqWr <= w;
        reqRd <= !w;
        reqAddr <= a;
        reqData <= d;
        @(posedge ref_clk);
        reqWr <= 1'b0;
        reqRd <= 1'b0;
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        req(1'b1, a, d);
    endtask
    // mask keeps bits the bench cannot predict out of the compare
    task automatic rreg(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        expQ.push_back({m, e & m});
        req(1'b0, a, 8'h00);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ************************************************************
    // monitor, noise and watchdog
    // ************************************************************
    always @(posedge ref_clk) begin
        pcmRxPin <= 1'($urandom);
        cycles++;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
        if (rspValid === 1'b1) begin
            if (expQ.size() == 0) check("unexpected rspValid", 8'h00, 8'hFF);
            else check("rspData", expQ[0][7:0], rspData & expQ[0][15:8]);
            if (expQ.size() != 0) void'(expQ.pop_front());
        end
    end
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        logic [7:0] r1, r2;
        logic [4:0] a;
        logic [1:0] m;
        logic       en;
        void'($urandom(69));
        {resetn, reqWr, reqRd, reqAddr, reqData} = '0;
        {pcmRxPin, monitorActivePin, powerFailPin} = '0;
        {failures, cmp_count, cycles} = '0;
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (400) @(posedge ref_clk);
        check("reqReady", 8'h01, {7'h00, reqReady});
        rreg(REG_MODE, MODE_RESET_VAL, 8'hFF);
        rreg(REG_ACCESS_STATUS, 8'h00, 8'h03);
        wreg(REG_MODE, 8'h01);
        rreg(REG_VERSION, {4'h0, VER}, 8'hFF);
        wreg(REG_VERSION, 8'hFF);
        rreg(REG_VERSION, {4'h0, VER}, 8'hFF);
        rreg(REG_MODE, 8'h01, 8'hFF);
        rreg(4'h9, 8'h00, 8'hFF);
        powerFailPin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        powerFailPin <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rreg(REG_VERSION, {4'h8, VER}, 8'hFF);
        r1 = 8'($urandom);
        r2 = 8'($urandom);
        a = 5'($urandom);
        wreg(REG_MODE, 8'h00);
        wreg(REG_MEM_DATA, r1);
        wreg(REG_MEM_CMD, BOOT_RESET_CMD);
        rreg(REG_ACCESS_STATUS, 8'h03, 8'h03);
        repeat (262) @(posedge ref_clk);
        rreg(REG_ACCESS_STATUS, 8'h00, 8'h03);
        wreg(REG_MODE, 8'h80);
        wreg(REG_MEM_ADDR, {3'b000, a});
        wreg(REG_MEM_CMD, 8'h01);
        repeat (4) @(posedge ref_clk);
        rreg(REG_MEM_DATA, r1, 8'hFF);
        wreg(REG_MEM_DATA, r2);
        wreg(REG_MEM_CMD, 8'h00);
        repeat (2) @(posedge ref_clk);
        wreg(REG_MEM_CMD, 8'h01);
        repeat (4) @(posedge ref_clk);
        rreg(REG_MEM_DATA, r2, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            wreg(REG_MODE, MODES[i]);
            wreg(REG_MEM_CMD, CMDS[i]);
            if (WAITS[i] > 2) rreg(REG_ACCESS_STATUS, 8'h01, 8'h01);
            repeat (WAITS[i] + 4) @(posedge ref_clk);
            rreg(REG_ACCESS_STATUS, 8'h00, 8'h01);
        end
        for (int i = 0; i < 8; i++) begin
            m = 2'(i >> 1);
            en = i[0];
            wreg(REG_MODE, {m, 3'b000, en, en, 1'b0});
            repeat (4) @(negedge ref_clk);
            check("pins", {3'b000, m[0] & en, m[0] & en, 3'b011 ^ {2'b00, !en}},
                {3'b000, subDataClockOe, subFrameSyncOe, pcmTxOe, tristateControlPin,
                monitorHandshakeEnable});
        end
        wreg(REG_MODE, 8'hCA);
        @(posedge ref_clk);
        repeat (8) begin
            @(negedge ref_clk);
            check("openDrainOe", {7'h00, !subDataClock}, {7'h00, subDataClockOe});
        end
        wreg(REG_MODE, 8'hC0);
        wreg(REG_ACCESS_STATUS, 8'h01);
        rreg(REG_ACCESS_STATUS, 8'h04, 8'h04);
        monitorActivePin <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rreg(REG_ACCESS_STATUS, 8'h00, 8'h04);
        monitorActivePin <= 1'b0;
        repeat (5) @(posedge ref_clk);
        wreg(REG_ACCESS_STATUS, 8'h01);
        wreg(REG_MODE, 8'h80);
        rreg(REG_ACCESS_STATUS, 8'h00, 8'h04);
        repeat (10) @(posedge ref_clk);
        complete_run();
    end
endmodule // tb
